// File: usm_baud_gen.sv
`include "usm_cfg.svh"

// ==========================================================
// half-period tick generator
module usm_baud_gen #(
	parameter int DIV_W = 16
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             srst,
	// control
	input  wire logic             run,
	input  wire logic             wide,
	input  wire logic [DIV_W-1:0] div,
	// output
	output logic                  tick
);

	logic [DIV_W-1:0] cnt_q;
	logic             tick_q;
	wire  [DIV_W-1:0] reload = wide ? div : {{(DIV_W-8){1'b0}}, div[7:0]};
	wire              zero   = (cnt_q == '0);

	always_ff @(posedge sys_clk) begin
		if (srst || !run) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= zero ? reload : cnt_q - 1'b1;
			tick_q <= zero;
		end
	end

	assign tick = tick_q;

endmodule : usm_baud_gen

// File: usm_cfg.svh
`ifndef USM_CFG_SVH
`define USM_CFG_SVH

// ==========================================================
// register byte addresses
`define USM_A_RCS       8'h00
`define USM_A_RXBUF     8'h04
`define USM_A_TXBUF     8'h08
`define USM_A_TXS       8'h0C
`define USM_A_BAUD      8'h10
`define USM_A_DIVH      8'h14
`define USM_A_DIVL      8'h18
`define USM_A_FLAGS     8'h1C
`define USM_A_IEN       8'h20

// ==========================================================
// rx_control_status fields
`define USM_RCS_SERIAL_PORT_ENABLE    7
`define USM_RCS_RX9     6
`define USM_RCS_SINGLE_RECEIVE_ENABLE    5
`define USM_RCS_CONTINUOUS_RECEIVE_ENABLE    4
`define USM_RCS_OERR    1
`define USM_RCS_RECEIVE_NINTH_DATA    0
// tx_control_status fields
`define USM_TXS_CLOCK_SOURCE_MASTER_SEL    7
`define USM_TXS_TX9     6
`define USM_TXS_TRANSMIT_ENABLE    5
`define USM_TXS_SYNC    4
`define USM_TXS_SHIFT_REGISTER_EMPTY    1
`define USM_TXS_TRANSMIT_NINTH_DATA    0
// baud_control fields
`define USM_BC_RCIDL    6
`define USM_BC_POL      4
`define USM_BC_WIDE     3
// flag and enable fields
`define USM_F_TX        0
`define USM_F_RX        1

// ==========================================================
// reset values and counts
`define USM_RST_BYTE    8'h00
`define USM_RST_DIV     16'h0000
`define USM_BITS_8      4'h7
`define USM_BITS_9      4'h8
`define USM_RESP_OK     2'h0
`define USM_RESP_ERR    2'h2

`endif

// File: usm_periph_model.sv
// ==========================================================
// external synchronous peripheral
module usm_periph_model (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       srst,
	// link
	input  wire logic       ck,
	input  wire logic       pol,
	input  wire logic       nine,
	input  wire logic       dev_oe,
	input  wire logic       line,
	input  wire logic [8:0] send_word,
	// results
	output logic            dt,
	output logic [8:0]      got_word,
	output logic            got_q
);
	logic       ck_q;
	logic       oe_q;
	logic       line_q;
	logic [3:0] cnt_q;
	wire        fall = ck_q & ~(ck ^ pol);
	wire        last = (cnt_q == (nine ? 4'h8 : 4'h7));
	// next bit presented right after each fall, lsb first
	assign dt = send_word[cnt_q];
	// line and drive seen just before the fall, as a real receiver latches them
	always_ff @(posedge sys_clk) begin
		ck_q   <= ck ^ pol;
		oe_q   <= dev_oe;
		line_q <= line;
		got_q  <= fall & oe_q & last;
		if (srst) begin
			cnt_q <= 4'h0;
		end else if (fall) begin
			cnt_q <= last ? 4'h0 : cnt_q + 4'h1;
			// capture at falling edge, lsb first
			if (oe_q) got_word <= ((cnt_q == 4'h0) ? 9'h000 : got_word) | ({8'h00, line_q} << cnt_q);
		end
	end
endmodule : usm_periph_model

// File: usm_pkg.sv
// ==========================================================
// shared types
package usm_pkg;

	typedef enum logic [1:0] {
		USM_IDLE = 2'b00,
		USM_TX   = 2'b01,
		USM_RX   = 2'b10
	} usm_state_t;

	typedef struct packed {
		logic ck;
		logic ck_oe;
		logic dt;
		logic dt_oe;
	} usm_pins_t;

	typedef struct packed {
		logic [7:0] data;
		logic       ninth;
	} usm_word_t;

endpackage : usm_pkg

// File: usm_sync_master.sv
// ==========================================================
// What this block does
// - clock master only while the clock source select bit is set.
// - half duplex: transmit and receive never run together.
// - synchronous operation needs the synchronous select bit.
// - port enable turns pins into shift clock and data lines.
// - master drives the shift clock for both directions.
// - polarity bit picks the idle level of the clock line.
// - shift register reloads from buffer right after the last bit.
// - buffer to shift register transfer takes one cycle, then flag sets.
// - buffer empty flag ignores enables and software; buffer write clears it.
// - transmit request only while transmit interrupt enable is set.
// - read-only shift register empty status; shift register not visible.
// - divisor registers and width select set the shift clock rate.
// - nine-bit option sends the ninth data bit with each word.
// - single or continuous receive enable starts reception.
// - data line sampled on each falling shift clock edge.
// - single receives one word; continuous keeps going and wins.
// - receive complete flag sets per word; request needs its enable.
// - clearing continuous receive enable clears the overrun status.
// - reading the receive buffer clears the receive complete flag.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`include "usm_cfg.svh"

module usm_sync_master
	import usm_pkg::*;
#(
	parameter int DIV_W = 16
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        srst,
	// axi4-lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// shift clock line
	output logic             ck_o,
	output logic             ck_oe,
	// serial data line
	input  wire logic        dt_i,
	output logic             dt_o,
	output logic             dt_oe,
	// interrupt requests
	output logic             tx_irq,
	output logic             rx_irq
);

	// ==========================================================
	// state
	usm_state_t     st_q, st_d;
	usm_pins_t      pin_q, pin_d;
	usm_word_t      rxw;
	logic [8:0]     tsr_q, tsr_d;
	logic [8:0]     rsr_q, rsr_d;
	logic [3:0]     bit_q, bit_d;
	logic           half_q, half_d;
	logic           load, rx_done;
	logic           dt_m_q, dt_s_q;
	logic           serial_port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q, oerr_q, receive_ninth_data_q;
	logic           clock_source_master_sel_q, tx9_q, transmit_enable_q, sync_q, transmit_ninth_data_q;
	logic           pol_q, wide_q;
	logic [7:0]     divh_q, divl_q;
	logic [7:0]     txbuf_q, rxbuf_q;
	logic           tbe_q, rcf_q, txie_q, rcie_q;
	logic           tx_irq_q, rx_irq_q;
	logic           awr_q, bvalid_q, arr_q, rvalid_q;
	logic [1:0]     bresp_q, rresp_q;
	logic [31:0]    rdata_q;
	logic           tick;

	// ==========================================================
	// bus decode
	wire       aw_take = s_axi_awvalid & s_axi_wvalid & ~awr_q & ~bvalid_q;
	wire       ar_take = s_axi_arvalid & ~arr_q & ~rvalid_q;
	wire       wr_en   = awr_q & s_axi_wstrb[0];
	wire       rd_en   = arr_q;
	wire [7:0] wd      = s_axi_wdata[7:0];
	wire       w_rcs   = wr_en & (s_axi_awaddr == `USM_A_RCS);
	wire       w_txbuf = wr_en & (s_axi_awaddr == `USM_A_TXBUF);
	wire       w_txs   = wr_en & (s_axi_awaddr == `USM_A_TXS);
	wire       w_baud  = wr_en & (s_axi_awaddr == `USM_A_BAUD);
	wire       w_divh  = wr_en & (s_axi_awaddr == `USM_A_DIVH);
	wire       w_divl  = wr_en & (s_axi_awaddr == `USM_A_DIVL);
	wire       w_ien   = wr_en & (s_axi_awaddr == `USM_A_IEN);
	wire       r_rxbuf = rd_en & (s_axi_araddr == `USM_A_RXBUF);
	wire       w_hit   = (s_axi_awaddr == `USM_A_RCS) | (s_axi_awaddr == `USM_A_RXBUF)
	                   | (s_axi_awaddr == `USM_A_TXBUF) | (s_axi_awaddr == `USM_A_TXS)
	                   | (s_axi_awaddr == `USM_A_BAUD) | (s_axi_awaddr == `USM_A_DIVH)
	                   | (s_axi_awaddr == `USM_A_DIVL) | (s_axi_awaddr == `USM_A_FLAGS)
	                   | (s_axi_awaddr == `USM_A_IEN);

	// ==========================================================
	// register read view
	wire       shift_register_empty = (st_q != USM_TX) & ~load;
	wire [7:0] rcs_v = {serial_port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q, 2'b00, oerr_q, receive_ninth_data_q};
	wire [7:0] txs_v = {clock_source_master_sel_q, tx9_q, transmit_enable_q, sync_q, 2'b00, shift_register_empty, transmit_ninth_data_q};
	wire [7:0] bc_v  = {1'b0, st_q != USM_RX, 1'b0, pol_q, wide_q, 3'b000};
	wire [7:0] fl_v  = {6'b000000, rcf_q, tbe_q};
	wire [7:0] ie_v  = {6'b000000, rcie_q, txie_q};
	logic [7:0] rd_byte;
	logic       rd_hit;

	always_comb begin
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			`USM_A_RCS:   rd_byte = rcs_v;
			`USM_A_RXBUF: rd_byte = rxbuf_q;
			`USM_A_TXBUF: rd_byte = txbuf_q;
			`USM_A_TXS:   rd_byte = txs_v;
			`USM_A_BAUD:  rd_byte = bc_v;
			`USM_A_DIVH:  rd_byte = divh_q;
			`USM_A_DIVL:  rd_byte = divl_q;
			`USM_A_FLAGS: rd_byte = fl_v;
			`USM_A_IEN:   rd_byte = ie_v;
			default: begin
				rd_byte = `USM_RST_BYTE;
				rd_hit  = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// axi4-lite handshakes
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			awr_q    <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q  <= `USM_RESP_OK;
			arr_q    <= 1'b0;
			rvalid_q <= 1'b0;
			rresp_q  <= `USM_RESP_OK;
			rdata_q  <= '0;
		end else begin
			awr_q <= aw_take;
			arr_q <= ar_take;
			if (awr_q) begin
				bvalid_q <= 1'b1;
				bresp_q  <= w_hit ? `USM_RESP_OK : `USM_RESP_ERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
			if (arr_q) begin
				rvalid_q <= 1'b1;
				rresp_q  <= rd_hit ? `USM_RESP_OK : `USM_RESP_ERR;
				rdata_q  <= {24'h000000, rd_byte};
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// control registers
	wire go_master = serial_port_enable_q & sync_q & clock_source_master_sel_q;
	wire rx_req    = single_receive_enable_q | continuous_receive_enable_q;
	wire continuous_receive_enable_off  = w_rcs & ~wd[`USM_RCS_CONTINUOUS_RECEIVE_ENABLE];

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			{serial_port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q, receive_ninth_data_q} <= '0;
			{clock_source_master_sel_q, tx9_q, transmit_enable_q, sync_q, transmit_ninth_data_q} <= '0;
			{pol_q, wide_q, txie_q, rcie_q}         <= '0;
			divh_q <= 8'(`USM_RST_DIV >> 8);
			divl_q <= 8'(`USM_RST_DIV);
		end else begin
			if (w_rcs) begin
				serial_port_enable_q <= wd[`USM_RCS_SERIAL_PORT_ENABLE];
				rx9_q  <= wd[`USM_RCS_RX9];
				single_receive_enable_q <= wd[`USM_RCS_SINGLE_RECEIVE_ENABLE];
				continuous_receive_enable_q <= wd[`USM_RCS_CONTINUOUS_RECEIVE_ENABLE];
			end else if (rx_done && !continuous_receive_enable_q) begin
				single_receive_enable_q <= 1'b0;
			end
			if (rx_done)
				receive_ninth_data_q <= rxw.ninth;
			if (w_txs) begin
				clock_source_master_sel_q <= wd[`USM_TXS_CLOCK_SOURCE_MASTER_SEL];
				tx9_q  <= wd[`USM_TXS_TX9];
				transmit_enable_q <= wd[`USM_TXS_TRANSMIT_ENABLE];
				sync_q <= wd[`USM_TXS_SYNC];
				transmit_ninth_data_q <= wd[`USM_TXS_TRANSMIT_NINTH_DATA];
			end
			if (w_baud) begin
				pol_q  <= wd[`USM_BC_POL];
				wide_q <= wd[`USM_BC_WIDE];
			end
			if (w_divh)
				divh_q <= wd;
			if (w_divl)
				divl_q <= wd;
			if (w_ien) begin
				txie_q <= wd[`USM_F_TX];
				rcie_q <= wd[`USM_F_RX];
			end
		end
	end

	// ==========================================================
	// buffers and flags
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			txbuf_q  <= `USM_RST_BYTE;
			rxbuf_q  <= `USM_RST_BYTE;
			tbe_q    <= 1'b1;
			rcf_q    <= 1'b0;
			oerr_q   <= 1'b0;
			tx_irq_q <= 1'b0;
			rx_irq_q <= 1'b0;
		end else begin
			if (w_txbuf)
				txbuf_q <= wd;
			if (load)
				tbe_q <= 1'b1;
			else if (w_txbuf)
				tbe_q <= 1'b0;
			if (rx_done)
				rcf_q <= 1'b1;
			else if (r_rxbuf)
				rcf_q <= 1'b0;
			if (rx_done && (!rcf_q || r_rxbuf))
				rxbuf_q <= rxw.data;
			if (rx_done && rcf_q && !r_rxbuf)
				oerr_q <= 1'b1;
			else if (continuous_receive_enable_off)
				oerr_q <= 1'b0;
			tx_irq_q <= tbe_q & txie_q;
			rx_irq_q <= rcf_q & rcie_q;
		end
	end

	// ==========================================================
	// shift clock generator
	usm_baud_gen #(
		.DIV_W (DIV_W)
	) u_baud (
		.sys_clk (sys_clk),
		.srst    (srst),
		.run     (st_q != USM_IDLE),
		.wide    (wide_q),
		.div     ({divh_q, divl_q}),
		.tick    (tick)
	);

	// ==========================================================
	// data line synchroniser
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			dt_m_q <= 1'b0;
			dt_s_q <= 1'b0;
		end else begin
			dt_m_q <= dt_i;
			dt_s_q <= dt_m_q;
		end
	end

	// ==========================================================
	// shift engine
	wire       nine     = (st_q == USM_TX) ? tx9_q : rx9_q;
	wire [3:0] last_bit = nine ? `USM_BITS_9 : `USM_BITS_8;
	wire       is_last  = (bit_q == last_bit);
	wire       tx_go    = go_master & transmit_enable_q & ~tbe_q;
	wire [8:0] rsr_shift = {dt_s_q, rsr_q[8:1]};

	assign rxw.data  = rx9_q ? rsr_shift[7:0] : rsr_shift[8:1];
	assign rxw.ninth = rx9_q & rsr_shift[8];

	always_comb begin
		st_d    = st_q;
		tsr_d   = tsr_q;
		rsr_d   = rsr_q;
		bit_d   = bit_q;
		half_d  = half_q;
		pin_d   = pin_q;
		load    = 1'b0;
		rx_done = 1'b0;
		unique case (st_q)
			USM_IDLE: begin
				pin_d.ck = 1'b0;
				half_d   = 1'b0;
				bit_d    = '0;
				if (tx_go) begin
					load = 1'b1;
					st_d = USM_TX;
				end else if (go_master && rx_req) begin
					st_d = USM_RX;
				end
			end
			USM_TX: begin
				if (!go_master || !transmit_enable_q) begin
					st_d     = USM_IDLE;
					pin_d.ck = 1'b0;
				end else if (tick && !half_q) begin
					pin_d.ck = 1'b1;
					pin_d.dt = tsr_q[0];
					half_d   = 1'b1;
				end else if (tick) begin
					pin_d.ck = 1'b0;
					half_d   = 1'b0;
					tsr_d    = {1'b0, tsr_q[8:1]};
					bit_d    = bit_q + 4'h1;
					if (is_last) begin
						bit_d = '0;
						if (!tbe_q)
							load = 1'b1;
						else
							st_d = USM_IDLE;
					end
				end
			end
			USM_RX: begin
				if (!go_master || !rx_req) begin
					st_d     = USM_IDLE;
					pin_d.ck = 1'b0;
				end else if (tick && !half_q) begin
					pin_d.ck = 1'b1;
					half_d   = 1'b1;
				end else if (tick) begin
					pin_d.ck = 1'b0;
					half_d   = 1'b0;
					rsr_d    = rsr_shift;
					bit_d    = bit_q + 4'h1;
					if (is_last) begin
						rx_done = 1'b1;
						st_d    = USM_IDLE;
					end
				end
			end
		endcase
		if (load)
			tsr_d = {transmit_ninth_data_q, txbuf_q};
		pin_d.ck_oe = go_master;
		pin_d.dt_oe = (st_d == USM_TX);
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_q   <= USM_IDLE;
			tsr_q  <= '0;
			rsr_q  <= '0;
			bit_q  <= '0;
			half_q <= 1'b0;
			pin_q  <= '0;
		end else begin
			st_q   <= st_d;
			tsr_q  <= tsr_d;
			rsr_q  <= rsr_d;
			bit_q  <= bit_d;
			half_q <= half_d;
			pin_q  <= pin_d;
		end
	end

	// ==========================================================
	// outputs
	logic ck_out_q;

	always_ff @(posedge sys_clk) begin
		if (srst)
			ck_out_q <= 1'b0;
		else
			ck_out_q <= pin_d.ck ^ pol_q;
	end

	assign ck_o          = ck_out_q;
	assign ck_oe         = pin_q.ck_oe;
	assign dt_o          = pin_q.dt;
	assign dt_oe         = pin_q.dt_oe;
	assign tx_irq        = tx_irq_q;
	assign rx_irq        = rx_irq_q;
	assign s_axi_awready = awr_q;
	assign s_axi_wready  = awr_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arr_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;

endmodule : usm_sync_master

// File: usm_sync_master_chk.sv
// ==========================================================
// port checker
module usm_sync_master_chk (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        srst,
	// register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// link and requests
	input wire logic        ck_o,
	input wire logic        ck_oe,
	input wire logic        dt_o,
	input wire logic        dt_oe,
	input wire logic        rx_irq
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	// ==========================================================
	// idle clock level seen at frame start
	logic oe_q;
	logic idle_q;
	always_ff @(posedge sys_clk) begin
		oe_q <= dt_oe;
		if (dt_oe && !oe_q) idle_q <= ck_o;
	end

	sequence wr_take;
		s_axi_awready && s_axi_wready;
	endsequence
	sequence wr_done;
		s_axi_bvalid && !s_axi_awready;
	endsequence

	// ==========================================================
	// assertions
	AST_RST_QUIET: assert property ($fell(srst) |-> !s_axi_bvalid && !s_axi_rvalid && !ck_oe && !dt_oe)
		else $error("outputs active right after reset");
	AST_WR_LAT: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
		|=> wr_take ##1 wr_done) else $error("write answer out of time");
	AST_RD_LAT: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
		|=> s_axi_arready ##1 s_axi_rvalid) else $error("read answer out of time");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	AST_OE_CK: assert property (dt_oe |-> ck_oe)
		else $error("data driven without clock drive");
	AST_IDLE_BACK: assert property ($fell(dt_oe) |-> ck_o == idle_q)
		else $error("clock not idle after frame");
	AST_DT_ON_RISE: assert property (dt_oe && $past(dt_oe) && $changed(dt_o) |-> $changed(ck_o)
		&& ck_o != idle_q)
		else $error("data changed off the rising edge");
	AST_DT_AT_FALL: assert property (dt_oe && $past(dt_oe) && $changed(ck_o) && ck_o == idle_q
		|-> $stable(dt_o))
		else $error("data moved at falling edge");
	AST_RX_HALF: assert property ($rose(rx_irq) |-> !dt_oe)
		else $error("word received during transmit");
endmodule : usm_sync_master_chk

// File: usm_sync_master_tb.sv
`include "usm_cfg.svh"
`define CHK(e, a) begin \
	compares++; \
	if ((a) !== (e)) begin \
		miscompares++; \
		$display("[FAIL] t=%0t exp=%0h got=%0h", $time, (e), (a)); \
	end \
end

module usm_sync_master_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// signals
	logic        sys_clk = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic        s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b1;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        ck_o, ck_oe, dt_o, dt_oe, tx_irq, rx_irq;
	logic        m_dt, m_got, m_pol = 1'b0, m_rst = 1'b0, nine = 1'b0, bit9;
	logic [8:0]  m_word = 9'h000, m_got_word, lv;
	logic [7:0]  d;
	logic [33:0] ev;
	logic [33:0] bq[$];
	logic [8:0]  lq[$];
	integer      seed = 32'h2518;
	int          miscompares = 0, compares = 0, cyc = 0;
	wire         line = dt_oe ? dt_o : m_dt;

	always #5 sys_clk = ~sys_clk;

	usm_sync_master dut (
		.sys_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .ck_o, .ck_oe, .dt_i(line), .dt_o, .dt_oe, .tx_irq, .rx_irq
	);
	usm_periph_model u_peer (
		.sys_clk, .srst(srst | m_rst), .ck(ck_o), .pol(m_pol), .nine, .dev_oe(dt_oe), .line,
		.send_word(m_word), .dt(m_dt), .got_word(m_got_word), .got_q(m_got)
	);

	// ==========================================================
	// bus master
	task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r);
		bq.push_back({r, 32'h0});
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {24'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] v);
		bq.push_back({2'h0, 24'h0, v});
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b1;
		@(posedge sys_clk);
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic end_sim;
		if (miscompares == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim

	// ==========================================================
	// result watcher and timeout
	always @(posedge sys_clk) begin
		cyc++;
		if (s_axi_bvalid && s_axi_bready) begin
			ev = bq.pop_front();
			`CHK(ev, {s_axi_bresp, 32'h0})
		end
		if (s_axi_rvalid && s_axi_rready) begin
			ev = bq.pop_front();
			`CHK(ev, {s_axi_rresp, s_axi_rdata})
		end
		if (m_got) begin
			lv = lq.pop_front();
			`CHK(lv, m_got_word)
		end
		if (cyc == 6000) begin
			miscompares++;
			end_sim();
		end
	end

	// ==========================================================
	// scenarios
	initial begin
		repeat (4) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		rd(`USM_A_FLAGS, 8'h01);
		`CHK(1'b0, tx_irq)
		rd(`USM_A_TXS, 8'h02);
		wr(8'h24, 8'hFF, `USM_RESP_ERR);
		for (int c = 0; c < 2; c++) begin
			nine = c[0];
			bit9 = 1'($random(seed));
			wr(`USM_A_BAUD, {3'h0, nine, nine, 3'h0}, `USM_RESP_OK);
			wr(`USM_A_DIVH, {7'h0, !nine}, `USM_RESP_OK);
			wr(`USM_A_DIVL, 8'h03, `USM_RESP_OK);
			wr(`USM_A_RCS, {1'b1, nine, 6'h0}, `USM_RESP_OK);
			wr(`USM_A_TXS, {1'b1, nine, 2'h3, 3'h0, bit9}, `USM_RESP_OK);
			rd(`USM_A_TXS, {1'b1, nine, 2'h3, 3'h1, bit9});
			wr(`USM_A_IEN, 8'h03, `USM_RESP_OK);
			m_pol <= nine;
			m_rst <= 1'b1;
			@(posedge sys_clk);
			m_rst <= 1'b0;
			repeat (2) begin
				d = 8'($random(seed));
				wr(`USM_A_TXBUF, d, `USM_RESP_OK);
				lq.push_back({nine & bit9, d});
			end
			while (lq.size() != 0) @(posedge sys_clk);
			`CHK(1'b1, tx_irq)
			rd(`USM_A_FLAGS, 8'h01);
			rd(`USM_A_TXS, {1'b1, nine, 2'h3, 3'h1, bit9});
			wr(`USM_A_TXS, {1'b1, nine, 2'h1, 3'h0, bit9}, `USM_RESP_OK);
			m_word <= 9'($random(seed));
			wr(`USM_A_RCS, {1'b1, nine, 1'b1, nine, 4'h0}, `USM_RESP_OK);
			while (!rx_irq) @(posedge sys_clk);
			// continuous mode: let a second word complete unread to raise overrun
			if (nine) repeat (100) @(posedge sys_clk);
			rd(`USM_A_RCS, {1'b1, nine, nine, nine, 2'h0, nine, nine & m_word[8]});
			rd(`USM_A_RXBUF, m_word[7:0]);
			wr(`USM_A_RCS, {1'b1, nine, 6'h0}, `USM_RESP_OK);
			rd(`USM_A_RCS, {1'b1, nine, 5'h0, nine & m_word[8]});
			rd(`USM_A_FLAGS, 8'h01);
			`CHK(1'b0, rx_irq)
		end
		end_sim();
	end
endmodule : usm_sync_master_tb

bind usm_sync_master usm_sync_master_chk u_chk (
	.sys_clk, .srst, .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_wready,
	.s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .ck_o, .ck_oe, .dt_o, .dt_oe, .rx_irq
);
